// file: src/tsc_coeff_mem.sv
// Per-channel gain coefficient store with two registered read ports
`timescale 1ns/100ps
`include "tsc_map.svh"
module tsc_coeff_mem
  import tsc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              wr_en,
  input  wire tsc_pkg::tsc_chan_t wr_addr,
  input  wire tsc_pkg::tsc_byte_t wr_data,
  input  wire tsc_pkg::tsc_chan_t rd_a_addr,
  output tsc_pkg::tsc_byte_t      rd_a_data,
  input  wire tsc_pkg::tsc_chan_t rd_b_addr,
  output tsc_pkg::tsc_byte_t      rd_b_data
);
  tsc_byte_t mem [`TSC_NUM_CH];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `TSC_NUM_CH; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_a_data <= 8'h00;
      rd_b_data <= 8'h00;
    end else begin
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
    end
  end
endmodule : tsc_coeff_mem

// file: src/tsc_conditioner.sv
// Touch signal conditioning: compensation, filtering, baseline, threshold, large activation
`timescale 1ns/100ps
`include "tsc_map.svh"
module tsc_conditioner
  import tsc_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               sample_valid,
  input  wire tsc_pkg::tsc_chan_t  sample_channel,
  input  wire tsc_pkg::tsc_sample_t sample_value,
  input  wire logic               frame_done,
  input  wire tsc_pkg::tsc_byte_t  reg_addr,
  input  wire tsc_pkg::tsc_byte_t  reg_wdata,
  input  wire logic               reg_write,
  input  wire logic               reg_read,
  output tsc_pkg::tsc_byte_t       reg_rdata,
  output logic                    reg_rvalid,
  output logic                    touch_present,
  output logic                    oversize_flag,
  output logic [`TSC_NUM_CH-1:0]  channel_touched
);
  import tsc_pkg::*;

  function automatic tsc_sample_t compensate(input tsc_sample_t raw, input tsc_byte_t coeff);
    logic [23:0] prod;
    prod = raw * coeff;
    if (coeff == 8'h00) begin
      return raw;
    end
    if (|prod[23:22]) begin
      return 16'hFFFF;
    end
    return prod[21:6];
  endfunction : compensate

  function automatic tsc_sample_t median_of(input tsc_hist_t h, input logic [3:0] len);
    logic [3:0]  below;
    logic [3:0]  same;
    tsc_sample_t pick;
    pick = h[0];
    for (int i = 0; i < `TSC_HIST_LEN; i++) begin
      below = 4'h0;
      same  = 4'h0;
      for (int j = 0; j < `TSC_HIST_LEN; j++) begin
        if (4'(j) < len && h[j] < h[i]) begin
          below = below + 4'h1;
        end else if (4'(j) < len && h[j] == h[i]) begin
          same = same + 4'h1;
        end
      end
      if (4'(i) < len && below <= len[3:1] && len[3:1] < below + same) begin
        pick = h[i];
      end
    end
    return pick;
  endfunction : median_of

  function automatic tsc_sample_t filter_step(input tsc_byte_t kind, input tsc_byte_t weight,
                                              input tsc_hist_t h, input tsc_sample_t prev);
    logic signed [16:0] diff;
    logic [18:0]        sum;
    logic               short_ok;
    tsc_sample_t        res;
    diff     = $signed({1'b0, h[0]}) - $signed({1'b0, prev});
    sum      = 19'h0_0000;
    short_ok = weight >= 8'h01 && weight <= 8'h03;
    res      = h[0];
    if (kind[7:2] == 6'h00) begin
      unique case (tsc_filt_kind_t'(kind[1:0]))
        TSC_FILT_NONE: res = h[0];
        TSC_FILT_MEDIAN: begin
          if (weight == 8'h03 || weight == 8'h05 || weight == 8'h07 || weight == 8'h09) begin
            res = median_of(h, weight[3:0]);
          end
        end
        TSC_FILT_IIR: begin
          if (short_ok) begin
            res = 16'($signed({1'b0, prev}) + (diff >>> weight[1:0]));
          end
        end
        TSC_FILT_AVG: begin
          if (short_ok) begin
            for (int i = 0; i < 8; i++) begin
              if (i < (1 << weight[1:0])) begin
                sum = sum + 19'(h[i]);
              end
            end
            res = 16'(sum >> weight[1:0]);
          end
        end
      endcase
    end
    return res;
  endfunction : filter_step

  function automatic tsc_sample_t slew(input tsc_sample_t old_v, input tsc_sample_t new_v,
                                       input tsc_byte_t rise, input tsc_byte_t fall);
    if (new_v > old_v && new_v - old_v > 16'(rise)) begin
      return old_v + 16'(rise);
    end
    if (old_v > new_v && old_v - new_v > 16'(fall)) begin
      return old_v - 16'(fall);
    end
    return new_v;
  endfunction : slew

  tsc_byte_t   cmd;
  tsc_byte_t   thr_x, thr_y, hyst, per_l, per_h, rise_slew_limit, fall_slew_limit;
  tsc_byte_t   sample_filter_kind, sample_filter_weight, ref_filter_kind, ref_filter_weight;
  tsc_byte_t   big_l, big_h, xcount;
  logic [3:0]  frame_cnt;
  tsc_hist_t   hist   [`TSC_NUM_CH];
  tsc_sample_t filt   [`TSC_NUM_CH];
  tsc_sample_t bfilt  [`TSC_NUM_CH];
  tsc_sample_t base   [`TSC_NUM_CH];
  tsc_sample_t pend   [`TSC_NUM_CH];
  logic        p1_valid, p2_valid, frame_touch, pend_ok;
  tsc_chan_t   p1_ch, p2_ch;
  tsc_sample_t p1_raw, comp_val;
  tsc_byte_t   coeff_a, coeff_b, rd_addr, ans_addr;
  logic        rd_pend;
  logic [15:0] per_cnt;
  logic [19:0] amp_sum;
  tsc_hist_t   next_hist;
  logic signed [16:0] delta;
  logic [8:0]  thr_eff;
  tsc_byte_t   thr_sel;
  logic        wr_cmd, wr_comp;
  logic [15:0] big_limit;
  logic        over_thr;

  assign wr_cmd    = reg_write && reg_addr == `TSC_REG_CMD;
  assign wr_comp   = reg_write && reg_addr[7:`TSC_CH_W] == 5'(`TSC_REG_COMP_BASE >> `TSC_CH_W);
  assign big_limit = {big_h, big_l};

  tsc_coeff_mem u_coeff (
    .clk       (clk),
    .resetn    (resetn),
    .wr_en     (wr_comp),
    .wr_addr   (reg_addr[`TSC_CH_W-1:0]),
    .wr_data   (reg_wdata),
    .rd_a_addr (sample_channel),
    .rd_a_data (coeff_a),
    .rd_b_addr (reg_addr[`TSC_CH_W-1:0]),
    .rd_b_data (coeff_b)
  );

  // Each command finishes in one cycle; a new write wins over completion
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd <= 8'h00;
    end else begin
      cmd <= wr_cmd ? (reg_wdata & `TSC_CMD_MASK) : 8'h00;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      thr_x <= `TSC_RST_THR_X;  thr_y <= `TSC_RST_THR_Y;  hyst <= `TSC_RST_HYST;
      per_l <= `TSC_RST_PER_L;  per_h <= `TSC_RST_PER_H;
      rise_slew_limit <= `TSC_RST_RISE;  fall_slew_limit <= `TSC_RST_FALL;
      sample_filter_kind <= `TSC_RST_FKIND;  sample_filter_weight <= `TSC_RST_FWEIGHT;
      ref_filter_kind <= `TSC_RST_BKIND;  ref_filter_weight <= `TSC_RST_BWEIGHT;
      big_l <= `TSC_RST_BIG;  big_h <= `TSC_RST_BIG;  xcount <= `TSC_RST_XCOUNT;
    end else if (cmd[`TSC_CMD_DEF]) begin
      thr_x <= `TSC_RST_THR_X;  thr_y <= `TSC_RST_THR_Y;  hyst <= `TSC_RST_HYST;
      per_l <= `TSC_RST_PER_L;  per_h <= `TSC_RST_PER_H;
      rise_slew_limit <= `TSC_RST_RISE;  fall_slew_limit <= `TSC_RST_FALL;
      sample_filter_kind <= `TSC_RST_FKIND;  sample_filter_weight <= `TSC_RST_FWEIGHT;
      ref_filter_kind <= `TSC_RST_BKIND;  ref_filter_weight <= `TSC_RST_BWEIGHT;
      big_l <= `TSC_RST_BIG;  big_h <= `TSC_RST_BIG;  xcount <= `TSC_RST_XCOUNT;
    end else if (reg_write) begin
      unique case (reg_addr)
        `TSC_REG_THR_X:   thr_x <= reg_wdata;
        `TSC_REG_THR_Y:   thr_y <= reg_wdata;
        `TSC_REG_HYST:    hyst <= reg_wdata;
        `TSC_REG_PER_L:   per_l <= reg_wdata;
        `TSC_REG_PER_H:   per_h <= reg_wdata;
        `TSC_REG_RISE:    rise_slew_limit <= reg_wdata;
        `TSC_REG_FALL:    fall_slew_limit <= reg_wdata;
        `TSC_REG_FKIND:   sample_filter_kind <= reg_wdata;
        `TSC_REG_FWEIGHT: sample_filter_weight <= reg_wdata;
        `TSC_REG_BKIND:   ref_filter_kind <= reg_wdata;
        `TSC_REG_BWEIGHT: ref_filter_weight <= reg_wdata;
        `TSC_REG_BIG_L:   big_l <= reg_wdata;
        `TSC_REG_BIG_H:   big_h <= reg_wdata;
        `TSC_REG_XCOUNT:  xcount <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Stage 1: gain compensation then both filter paths
  assign comp_val  = compensate(p1_raw, coeff_a);
  assign next_hist = {hist[p1_ch][`TSC_HIST_LEN-2:0], comp_val};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      p1_valid <= 1'b0;
      p1_ch    <= '0;
      p1_raw   <= 16'h0000;
      p2_valid <= 1'b0;
      p2_ch    <= '0;
    end else begin
      p1_valid <= sample_valid;
      p1_ch    <= sample_channel;
      p1_raw   <= sample_value;
      p2_valid <= p1_valid;
      p2_ch    <= p1_ch;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `TSC_NUM_CH; i++) begin
        hist[i]  <= '0;
        filt[i]  <= 16'h0000;
        bfilt[i] <= 16'h0000;
      end
    end else if (p1_valid) begin
      hist[p1_ch]  <= next_hist;
      filt[p1_ch]  <= filter_step(sample_filter_kind, sample_filter_weight,
                                  next_hist, filt[p1_ch]);
      bfilt[p1_ch] <= filter_step(ref_filter_kind, ref_filter_weight,
                                  next_hist, bfilt[p1_ch]);
    end
  end

  // Stage 2: conditioned value against the hysteresis-adjusted threshold
  assign delta   = $signed({1'b0, filt[p2_ch]}) - $signed({1'b0, base[p2_ch]});
  assign thr_sel = ({5'h00, p2_ch} < xcount) ? thr_x : thr_y;
  assign thr_eff = !channel_touched[p2_ch] ? {1'b0, thr_sel} :
                   (thr_sel > hyst) ? {1'b0, thr_sel - hyst} : 9'h000;
  assign over_thr = delta > $signed({8'h00, thr_eff});

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      channel_touched <= '0;
      frame_touch     <= 1'b0;
    end else begin
      if (p2_valid) begin
        channel_touched[p2_ch] <= over_thr;
      end
      // A sample landing on the frame edge opens the next frame
      if (frame_done) begin
        frame_touch <= p2_valid && over_thr;
      end else if (p2_valid && over_thr) begin
        frame_touch <= 1'b1;
      end
    end
  end

  // Large activation only raises a flag; touch outputs are untouched by it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      amp_sum       <= 20'h0_0000;
      oversize_flag <= 1'b0;
    end else if (frame_done) begin
      amp_sum       <= (p2_valid && big_limit != 16'h0000 && !delta[16]) ? 20'(delta) : 20'h0_0000;
      oversize_flag <= big_limit != 16'h0000 && amp_sum > {4'h0, big_limit};
    end else if (p2_valid && big_limit != 16'h0000 && !delta[16]) begin
      amp_sum <= (amp_sum > 20'hF_0000) ? amp_sum : amp_sum + 20'(delta);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_cnt     <= 4'h0;
      touch_present <= 1'b0;
    end else if (frame_done) begin
      frame_cnt     <= frame_cnt + 4'h1;
      touch_present <= frame_touch;
    end
  end

  // Baseline interval, deferred apply and forced rebaseline
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      per_cnt <= 16'h0000;
      pend_ok <= 1'b0;
      for (int i = 0; i < `TSC_NUM_CH; i++) begin
        base[i] <= 16'h0000;
        pend[i] <= 16'h0000;
      end
    end else if (cmd[`TSC_CMD_REBASE]) begin
      pend_ok <= 1'b0;
      for (int i = 0; i < `TSC_NUM_CH; i++) begin
        base[i] <= filt[i];
      end
    end else if (frame_done) begin
      if (frame_touch) begin
        per_cnt <= 16'h0000;
        pend_ok <= 1'b0;
      end else if (per_cnt + 16'h0001 >= {per_h, per_l}) begin
        per_cnt <= 16'h0000;
        pend_ok <= 1'b1;
        for (int i = 0; i < `TSC_NUM_CH; i++) begin
          pend[i] <= bfilt[i];
          if (pend_ok) begin
            base[i] <= slew(base[i], pend[i], rise_slew_limit, fall_slew_limit);
          end
        end
      end else begin
        per_cnt <= per_cnt + 16'h0001;
      end
    end
  end

  // Register reads answer two edges after the request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_pend    <= 1'b0;
      rd_addr    <= 8'h00;
      ans_addr   <= 8'h00;
      reg_rvalid <= 1'b0;
      reg_rdata  <= 8'h00;
    end else begin
      rd_pend    <= reg_read;
      rd_addr    <= reg_addr;
      reg_rvalid <= rd_pend;
      if (rd_pend) begin
        ans_addr <= rd_addr;
        unique case (rd_addr)
          `TSC_REG_CMD:     reg_rdata <= cmd;
          `TSC_REG_STATE:   reg_rdata <= {frame_cnt, 1'b0, oversize_flag, 1'b0, touch_present};
          `TSC_REG_THR_X:   reg_rdata <= thr_x;
          `TSC_REG_THR_Y:   reg_rdata <= thr_y;
          `TSC_REG_HYST:    reg_rdata <= hyst;
          `TSC_REG_PER_L:   reg_rdata <= per_l;
          `TSC_REG_PER_H:   reg_rdata <= per_h;
          `TSC_REG_RISE:    reg_rdata <= rise_slew_limit;
          `TSC_REG_FALL:    reg_rdata <= fall_slew_limit;
          `TSC_REG_FKIND:   reg_rdata <= sample_filter_kind;
          `TSC_REG_FWEIGHT: reg_rdata <= sample_filter_weight;
          `TSC_REG_BKIND:   reg_rdata <= ref_filter_kind;
          `TSC_REG_BWEIGHT: reg_rdata <= ref_filter_weight;
          `TSC_REG_BIG_L:   reg_rdata <= big_l;
          `TSC_REG_BIG_H:   reg_rdata <= big_h;
          `TSC_REG_XCOUNT:  reg_rdata <= xcount;
          default: reg_rdata <= (rd_addr[7:`TSC_CH_W] == 5'(`TSC_REG_COMP_BASE >> `TSC_CH_W))
                                ? coeff_b : 8'h00;
        endcase
      end
    end
  end

  a_cmd_autoclear: assert property (@(posedge clk) disable iff (!resetn)
    cmd[`TSC_CMD_REBASE] && !wr_cmd |=> !cmd[`TSC_CMD_REBASE])
    else $error("rebaseline command bit did not clear");

  a_rebase_copy: assert property (@(posedge clk) disable iff (!resetn)
    cmd[`TSC_CMD_REBASE] |=> base[0] == $past(filt[0]) && base[1] == $past(filt[1]))
    else $error("rebaseline did not copy filtered values");

  a_big_disabled: assert property (@(posedge clk) disable iff (!resetn)
    big_limit == 16'h0000 |=> amp_sum == 20'h0_0000 || $past(amp_sum) == amp_sum)
    else $error("sum accumulated while large limit is zero");

  a_big_flag_set: assert property (@(posedge clk) disable iff (!resetn)
    frame_done && big_limit != 16'h0000 && amp_sum > {4'h0, big_limit} |=> oversize_flag)
    else $error("large activation flag not raised");

  a_status_bit: assert property (@(posedge clk) disable iff (!resetn)
    reg_rvalid && ans_addr == `TSC_REG_STATE |-> reg_rdata[2] == $past(oversize_flag))
    else $error("status bit 2 does not show large activation");

  a_comp_skip: assert property (@(posedge clk) disable iff (!resetn)
    p1_valid && coeff_a == 8'h00 && sample_filter_kind == 8'h00
    |=> filt[$past(p1_ch)] == $past(p1_raw))
    else $error("zero coefficient did not pass raw value");

  a_touch_restart: assert property (@(posedge clk) disable iff (!resetn)
    frame_done && frame_touch && !cmd[`TSC_CMD_REBASE] |=> per_cnt == 16'h0000 && !pend_ok)
    else $error("touch did not restart baseline interval");

  a_rise_limit: assert property (@(posedge clk) disable iff (!resetn)
    !cmd[`TSC_CMD_REBASE] |=> {1'b0, base[0]} <= {1'b0, $past(base[0])} + 17'($past(rise_slew_limit)))
    else $error("baseline rose faster than rise limit");

  a_touch_thresh: assert property (@(posedge clk) disable iff (!resetn)
    p2_valid && !channel_touched[p2_ch] && delta > $signed({9'h000, thr_sel})
    |=> channel_touched[$past(p2_ch)])
    else $error("channel above threshold not marked touched");
endmodule : tsc_conditioner

// file: src/tsc_map.svh
// Register offsets, reset values and field positions of the touch conditioning block
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH

`define TSC_NUM_CH        8
`define TSC_CH_W          3
`define TSC_HIST_LEN      9
`define TSC_COMP_SHIFT    6

`define TSC_REG_CMD       8'h04
`define TSC_REG_STATE     8'h10
`define TSC_REG_THR_X     8'h23
`define TSC_REG_THR_Y     8'h24
`define TSC_REG_HYST      8'h2A
`define TSC_REG_PER_L     8'h2D
`define TSC_REG_PER_H     8'h2E
`define TSC_REG_RISE      8'h2F
`define TSC_REG_FALL      8'h30
`define TSC_REG_FKIND     8'h31
`define TSC_REG_FWEIGHT   8'h32
`define TSC_REG_BKIND     8'h33
`define TSC_REG_BWEIGHT   8'h34
`define TSC_REG_BIG_L     8'h35
`define TSC_REG_BIG_H     8'h36
`define TSC_REG_XCOUNT    8'h60
`define TSC_REG_COMP_BASE 8'h80

`define TSC_RST_THR_X     8'h37
`define TSC_RST_THR_Y     8'h28
`define TSC_RST_HYST      8'h04
`define TSC_RST_PER_L     8'h0A
`define TSC_RST_PER_H     8'h00
`define TSC_RST_RISE      8'h14
`define TSC_RST_FALL      8'h14
`define TSC_RST_FKIND     8'h02
`define TSC_RST_FWEIGHT   8'h01
`define TSC_RST_BKIND     8'h02
`define TSC_RST_BWEIGHT   8'h01
`define TSC_RST_BIG       8'h00
`define TSC_RST_XCOUNT    8'h04

`define TSC_CMD_REBASE    0
`define TSC_CMD_DEF       6
`define TSC_CMD_MASK      8'hE9
`define TSC_STATE_TOUCH   0
`define TSC_STATE_BIG     2

`endif

// file: src/tsc_pkg.sv
// Types shared by the touch conditioning block
package tsc_pkg;
  `include "tsc_map.svh"
  typedef logic [7:0]                 tsc_byte_t;
  typedef logic [15:0]                tsc_sample_t;
  typedef logic [`TSC_CH_W-1:0]       tsc_chan_t;
  typedef logic [`TSC_HIST_LEN-1:0][15:0] tsc_hist_t;
  typedef enum logic [1:0] {
    TSC_FILT_NONE,
    TSC_FILT_MEDIAN,
    TSC_FILT_IIR,
    TSC_FILT_AVG
  } tsc_filt_kind_t;
endpackage : tsc_pkg

// file: test/tb.sv
// Self-checking bench of the touch conditioning block against a reference model
`timescale 1ns/100ps
module tb;
  import tsc_pkg::*;
  logic         clk, resetn, sample_valid, frame_done;
  tsc_chan_t    sample_channel;
  tsc_sample_t  sample_value;
  tsc_byte_t    reg_addr, reg_wdata, reg_rdata, v;
  logic         reg_write, reg_read, reg_rvalid, touch_present, oversize_flag;
  logic [7:0]   channel_touched;
  int           num_errors, compares, seed, cyc;
  int           hq[8][$];
  int           fl[8], base[8], pend[8], lastc[8], coef[8];
  int           fk, fw, thx, thy, hy, lim, sum, frames, cnt, per, rise, fall;
  bit           pv, big, tp;
  bit [7:0]     tch;
  int           kt[11] = '{0, 1, 1, 1, 1, 2, 2, 2, 3, 3, 3};
  int           wt[11] = '{0, 3, 5, 7, 9, 1, 2, 3, 1, 2, 3};
  tsc_byte_t    ra[8] = '{8'h04, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h33, 8'h34, 8'h05};
  tsc_byte_t    rv[8] = '{8'h00, 8'h0A, 8'h00, 8'h14, 8'h14, 8'h02, 8'h01, 8'h00};

  tsc_conditioner i_tsc_conditioner (.clk(clk), .resetn(resetn),
    .sample_valid(sample_valid), .sample_channel(sample_channel),
    .sample_value(sample_value), .frame_done(frame_done), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .touch_present(touch_present),
    .oversize_flag(oversize_flag), .channel_touched(channel_touched));

  tsc_host_model i_tsc_host_model (.clk(clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Reference for one sample: gain, filter, delta, hysteresis, amplitude sum
  task automatic model(input int ch, input int raw);
    int x, f, d, s, t;
    int w[$];
    x = (coef[ch] == 0) ? raw : (raw * coef[ch]) >> 6;
    hq[ch].push_front(x);
    void'(hq[ch].pop_back());
    f = x;
    if (fk == 1 && fw inside {3, 5, 7, 9}) begin
      for (int i = 0; i < fw; i++) w.push_back(hq[ch][i]);
      w.sort();
      f = w[fw / 2];
    end
    if (fk == 2 && fw inside {[1:3]}) f = fl[ch] + ((x - fl[ch]) >>> fw);
    if (fk == 3 && fw inside {[1:3]}) begin
      s = 0;
      for (int i = 0; i < (1 << fw); i++) s += hq[ch][i];
      f = s >> fw;
    end
    fl[ch] = f;
    lastc[ch] = x;
    d = f - base[ch];
    t = (ch < 4) ? thx : thy;
    if (tch[ch]) t = (t > hy) ? t - hy : 0;
    tch[ch] = d > t;
    if (lim != 0 && d > 0) sum += d;
  endtask : model

  // Frame end: oversize decision, interval counting, slew-limited baseline
  task automatic frame_model;
    int dl;
    frames++;
    big = lim != 0 && sum > lim;
    tp = tch != 8'h00;
    if (tp) begin
      cnt = 0;
      pv = 1'b0;
    end else if (cnt + 1 >= ((per == 0) ? 1 : per)) begin
      if (pv) foreach (base[k]) begin
        dl = pend[k] - base[k];
        base[k] += (dl > rise) ? rise : (dl < -fall) ? -fall : dl;
      end
      pend = lastc;
      pv = 1'b1;
      cnt = 0;
    end else cnt++;
    sum = 0;
  endtask : frame_model

  task automatic samp(input int ch, input int raw);
    @(posedge clk) #1;
    sample_valid = 1'b1;
    sample_channel = ch[2:0];
    sample_value = raw[15:0];
    @(posedge clk) #1;
    sample_valid = 1'b0;
    sample_value = ~sample_value;
    model(ch, raw);
    repeat (3) @(posedge clk);
    #1 chk(channel_touched[ch], tch[ch]);
  endtask : samp

  task automatic frame(input int l, input int hi);
    lim = l;
    i_tsc_host_model.wr(8'h35, l[7:0]);
    i_tsc_host_model.wr(8'h36, l[15:8]);
    for (int k = 0; k < 8; k++) samp(k, {$random(seed)} % hi);
    @(posedge clk) #1;
    frame_done = 1'b1;
    @(posedge clk) #1;
    frame_done = 1'b0;
    frame_model();
    @(posedge clk) #1;
    chk(touch_present, tp);
    chk(oversize_flag, big);
    i_tsc_host_model.rd(8'h10, v);
    chk(v, {frames[3:0], 1'b0, big, 1'b0, tp});
  endtask : frame

  initial begin
    seed = 65;
    resetn = 1'b0;
    sample_valid = 1'b0;
    sample_channel = 3'h0;
    sample_value = 16'h0000;
    frame_done = 1'b0;
    thx = 55;
    thy = 40;
    hy = 4;
    per = 10;
    rise = 20;
    fall = 20;
    foreach (hq[k]) repeat (9) hq[k].push_back(0);
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    foreach (ra[i]) begin
      i_tsc_host_model.rd(ra[i], v);
      chk(v, rv[i]);
    end
    i_tsc_host_model.wr(8'h33, 8'h00);
    for (int k = 0; k < 8; k++) begin
      coef[k] = (k == 3) ? 64 : 40 + {$random(seed)} % 60;
      i_tsc_host_model.gain(k, coef[k]);
    end
    for (int i = 0; i < 11; i++) begin
      fk = kt[i];
      fw = wt[i];
      i_tsc_host_model.wr(8'h31, fk[7:0]);
      i_tsc_host_model.wr(8'h32, fw[7:0]);
      repeat (2) frame((i % 3 == 0) ? 0 : 100 + {$random(seed)} % 500, 150);
    end
    i_tsc_host_model.wr(8'h2D, 8'h01);
    per = 1;
    i_tsc_host_model.wr(8'h04, 8'h01);
    base = fl;
    pv = 1'b0;
    i_tsc_host_model.rd(8'h04, v);
    chk(v, 8'h00);
    repeat (2) frame(0, 150);
    i_tsc_host_model.wr(8'h23, 8'hFF);
    i_tsc_host_model.wr(8'h24, 8'hFF);
    thx = 255;
    thy = 255;
    repeat (6) frame(0, 150);
    i_tsc_host_model.wr(8'h23, 8'h14);
    i_tsc_host_model.wr(8'h24, 8'h14);
    thx = 20;
    thy = 20;
    repeat (2) frame(300, 150);
    // Restore-defaults command brings back the configuration values
    i_tsc_host_model.wr(8'h04, 8'h40);
    i_tsc_host_model.rd(8'h23, v);
    chk(v, 8'h37);
    i_tsc_host_model.rd(8'h2D, v);
    chk(v, 8'h0A);
    i_tsc_host_model.rd(8'h04, v);
    chk(v, 8'h00);
    give_verdict();
  end
endmodule : tb

// file: test/tsc_host_model.sv
// Host processor model driving the register port of the conditioning block
`timescale 1ns/100ps
module tsc_host_model
  import tsc_pkg::*;
(
  input  wire logic               clk,
  output tsc_pkg::tsc_byte_t       reg_addr,
  output tsc_pkg::tsc_byte_t       reg_wdata,
  output logic                    reg_write,
  output logic                    reg_read,
  input  wire tsc_pkg::tsc_byte_t  reg_rdata,
  input  wire logic               reg_rvalid
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
  end

  task automatic wr(input tsc_byte_t a, input tsc_byte_t d);
    @(posedge clk) #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge clk) #1;
    reg_write = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  // Unity gain is sent as zero so the scaling is skipped
  task automatic gain(input int ch, input int c);
    wr(8'h80 + ch[7:0], (c == 64) ? 8'h00 : c[7:0]);
  endtask : gain

  task automatic rd(input tsc_byte_t a, output tsc_byte_t d);
    d = 8'hxx;
    @(posedge clk) #1;
    reg_addr = a;
    reg_read = 1'b1;
    @(posedge clk) #1;
    reg_read = 1'b0;
    reg_addr = ~a;
    repeat (3) begin
      if (reg_rvalid === 1'b1) d = reg_rdata;
      @(posedge clk) #1;
    end
  endtask : rd
endmodule : tsc_host_model
